// ===== verilog/bsc_pkg.sv
// Shared constants and types for the buck sequencing slot configuration bank.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz mclk.
package bsc_pkg;

  // Number of step-down regulators served by this bank.
  localparam int unsigned NUM_BUCKS = 4;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [9:0] IDX_BUCK0_SEQ_CFG  = 10'h0a4;
  localparam logic [9:0] IDX_BUCK1_SEQ_CFG  = 10'h0a5;
  localparam logic [9:0] IDX_BUCK2_SEQ_CFG  = 10'h0a6;
  localparam logic [9:0] IDX_BUCK3_SEQ_CFG  = 10'h0a7;
  localparam logic [9:0] IDX_SEQ_STATUS     = 10'h0b0;

  // Field positions inside one configuration byte.
  localparam int unsigned SRC_MSB  = 7;
  localparam int unsigned SRC_LSB  = 6;
  localparam int unsigned UP_MSB   = 5;
  localparam int unsigned UP_LSB   = 3;
  localparam int unsigned DN_MSB   = 2;
  localparam int unsigned DN_LSB   = 0;

  // Sequencer source codes.
  localparam logic [1:0] SRC_SEQ_ZERO   = 2'h0;
  localparam logic [1:0] SRC_SEQ_ONE_A  = 2'h1;
  localparam logic [1:0] SRC_SEQ_ONE_B  = 2'h2;
  localparam logic [1:0] SRC_EXCLUDED   = 2'h3;

  // Bus answer codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status register field positions.
  localparam int unsigned STAT_EN_LSB  = 0;
  localparam int unsigned STAT_MGD_LSB = 4;
  localparam int unsigned STAT_SEL_LSB = 8;
  localparam int unsigned STAT_LOADED  = 12;

  // One configuration byte, packed in register bit order.
  typedef struct packed {
    logic [1:0] source;
    logic [2:0] upSlot;
    logic [2:0] downSlot;
  } bsc_cfg_t;

  // One time-slot step issued by a sequencer engine.
  typedef struct packed {
    logic       upStep;
    logic       downStep;
    logic [2:0] slot;
  } bsc_seq_evt_t;

endpackage

// ===== verilog/bsc_buck_slot.sv
// One regulator's sequencing configuration byte and the enable it steers.
// Assumes sequencer steps come from logic on mclk, so they are used unsynchronised.
`timescale 1ns/100ps
`default_nettype none

module bsc_buck_slot (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  loadOtp,
  input  wire bsc_pkg::bsc_cfg_t     otpValue,
  input  wire logic                  writeEn,
  input  wire logic [7:0]            writeData,
  input  wire bsc_pkg::bsc_seq_evt_t seqZeroEvt,
  input  wire bsc_pkg::bsc_seq_evt_t seqOneEvt,
  output bsc_pkg::bsc_cfg_t          cfg,
  output logic                       managed,
  output logic                       useSeqOne,
  output logic                       buckEnable
);

  bsc_pkg::bsc_seq_evt_t selEvt;
  logic                  upHit;
  logic                  downHit;

  // Code 00 picks sequencer zero, 01 and 10 both pick sequencer one.
  assign useSeqOne = (cfg.source == bsc_pkg::SRC_SEQ_ONE_A) ||
                     (cfg.source == bsc_pkg::SRC_SEQ_ONE_B);
  // Code 11 takes the regulator out of every sequence.
  assign managed   = (cfg.source != bsc_pkg::SRC_EXCLUDED);
  assign selEvt    = useSeqOne ? seqOneEvt : seqZeroEvt;

  // Slot numbers are plain binary, compared against the running slot.
  assign upHit   = managed && selEvt.upStep && (selEvt.slot == cfg.upSlot);
  assign downHit = managed && selEvt.downStep && (selEvt.slot == cfg.downSlot);

  // Reset clears the byte; the factory values land on the first edge after release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '0;
    end else if (loadOtp) begin
      cfg <= otpValue;
    end else if (writeEn) begin
      cfg <= bsc_pkg::bsc_cfg_t'(writeData);
    end
  end

  // A down step wins over an up step in the same cycle, so a collision leaves the rail off.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buckEnable <= 1'b0;
    end else if (downHit) begin
      buckEnable <= 1'b0;
    end else if (upHit) begin
      buckEnable <= 1'b1;
    end
  end

endmodule // bsc_buck_slot

`default_nettype wire

// ===== verilog/bsc_top.sv
// Buck sequencing slot configuration bank with its AXI4-Lite register slave.
// Assumes the sequencer engines and factory option store run on mclk and that
// the option values are stable from reset release onward.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Source code 00 selects sequencer zero; codes 01 and 10 select sequencer one.
// - Source code 11 removes the regulator from every sequence; no sequencer switches it.
// - Up slot field, bits 5 to 3, is the binary slot that enables the rail.
// - Down slot field, bits 2 to 0, is the binary slot that disables the rail.
// - Software writes and reads back every field of each buck register.
module bsc_top #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // Factory option values, one byte per regulator.
  input  wire bsc_pkg::bsc_cfg_t     otpBuck0,
  input  wire bsc_pkg::bsc_cfg_t     otpBuck1,
  input  wire bsc_pkg::bsc_cfg_t     otpBuck2,
  input  wire bsc_pkg::bsc_cfg_t     otpBuck3,
  // Slot steps from the two sequencer engines.
  input  wire bsc_pkg::bsc_seq_evt_t seqZeroEvt,
  input  wire bsc_pkg::bsc_seq_evt_t seqOneEvt,
  // Per-regulator results.
  output logic [3:0]                 buckEnable,
  output logic [3:0]                 buckManaged,
  // AXI4-Lite write address channel.
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int unsigned NB = bsc_pkg::NUM_BUCKS;

  // Load sequencing after reset.
  logic                   otpLoaded;
  logic                   loadOtp;

  // Held write address and data, taken in either order.
  logic                   awHeld;
  logic [ADDR_W-1:0]      awAddr;
  logic                   wHeld;
  logic [7:0]             wData;
  logic                   wLane0;

  // Write decode.
  logic                   writeFire;
  logic [9:0]             writeIdx;
  logic [NB-1:0]          writeHit;
  logic                   writeMapped;

  // Read decode.
  logic                   readFire;
  logic [9:0]             readIdx;
  logic [NB-1:0]          readHit;
  logic                   readStatus;
  logic                   readMapped;
  logic [31:0]            readWord;
  logic [31:0]            statusWord;

  // Per-regulator views.
  bsc_pkg::bsc_cfg_t      otpArr [NB];
  bsc_pkg::bsc_cfg_t      cfgArr [NB];
  logic [NB-1:0]          useSeqOne;
  logic [NB-1:0]          writeEn;
  logic [7:0]             cfgBytes [NB];

  // Printed register indices in regulator order.
  logic [9:0]             cfgIdx [NB];

  assign otpArr[0] = otpBuck0;
  assign otpArr[1] = otpBuck1;
  assign otpArr[2] = otpBuck2;
  assign otpArr[3] = otpBuck3;

  assign cfgIdx[0] = bsc_pkg::IDX_BUCK0_SEQ_CFG;
  assign cfgIdx[1] = bsc_pkg::IDX_BUCK1_SEQ_CFG;
  assign cfgIdx[2] = bsc_pkg::IDX_BUCK2_SEQ_CFG;
  assign cfgIdx[3] = bsc_pkg::IDX_BUCK3_SEQ_CFG;

  // The asynchronous reset can only give the flops a constant, so the factory
  // values are copied by a clocked load on the first edge after release.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      otpLoaded <= 1'b0;
    end else begin
      otpLoaded <= 1'b1;
    end
  end

  assign loadOtp = !otpLoaded;

  // The bus stays closed until the load is done, so a early write can never
  // be overwritten by the factory values a cycle later.
  assign s_axi_awready = otpLoaded && !awHeld;
  assign s_axi_wready  = otpLoaded && !wHeld;
  assign s_axi_arready = otpLoaded && !s_axi_rvalid;

  // A write completes once both halves are held and no answer is pending.
  assign writeFire   = awHeld && wHeld && !s_axi_bvalid;
  assign writeIdx    = awAddr[11:2];
  assign writeMapped = (|writeHit) || (writeIdx == bsc_pkg::IDX_SEQ_STATUS);

  // Capture the write address when it is offered.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (writeFire) begin
      awHeld <= 1'b0;
    end
  end

  // Capture the write data; only byte lane 0 carries register bits.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld  <= 1'b0;
      wData  <= '0;
      wLane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wData  <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (writeFire) begin
      wHeld  <= 1'b0;
    end
  end

  // Write answer: OKAY for any mapped word, SLVERR for a hole in the map.
  // The status word is read-only; a write to it is answered OKAY and dropped.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bsc_pkg::RESP_OKAY;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= writeMapped ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode runs straight off the offered address.
  assign readFire   = s_axi_arvalid && s_axi_arready;
  assign readIdx    = s_axi_araddr[11:2];
  assign readStatus = (readIdx == bsc_pkg::IDX_SEQ_STATUS);
  assign readMapped = (|readHit) || readStatus;

  // Status word shows live enables, membership and sequencer choice.
  assign statusWord = {19'h0, otpLoaded, useSeqOne, buckManaged, buckEnable};

  // Read data selection; unused upper bits read as zero.
  always_comb begin
    readWord = 32'h0;
    for (int i = 0; i < NB; i++) begin
      if (readHit[i]) begin
        readWord = {24'h0, cfgBytes[i]};
      end
    end
    if (readStatus) begin
      readWord = statusWord;
    end
  end

  // Read answer comes out of flops one cycle after the address is taken.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= bsc_pkg::RESP_OKAY;
    end else if (readFire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= readWord;
      s_axi_rresp  <= readMapped ? bsc_pkg::RESP_OKAY : bsc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // One configuration slot per regulator.
  for (genvar g = 0; g < NB; g++) begin : gBuck
    assign writeHit[g] = (writeIdx == cfgIdx[g]);
    assign readHit[g]  = (readIdx == cfgIdx[g]);
    assign writeEn[g]  = writeFire && writeHit[g] && wLane0;
    assign cfgBytes[g] = cfgArr[g];

    bsc_buck_slot uSlot (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .loadOtp    (loadOtp),
      .otpValue   (otpArr[g]),
      .writeEn    (writeEn[g]),
      .writeData  (wData),
      .seqZeroEvt (seqZeroEvt),
      .seqOneEvt  (seqOneEvt),
      .cfg        (cfgArr[g]),
      .managed    (buckManaged[g]),
      .useSeqOne  (useSeqOne[g]),
      .buckEnable (buckEnable[g])
    );
  end

endmodule // bsc_top

`default_nettype wire

// ===== bench/bsc_top_checker.sv
// Concurrent checks on the ports of the buck sequencing bank.
// Assumes it is bound into bsc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module bsc_top_checker (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire bsc_pkg::bsc_seq_evt_t seqZeroEvt,
  input wire bsc_pkg::bsc_seq_evt_t seqOneEvt,
  input wire logic [3:0]            buckEnable,
  input wire logic [3:0]            buckManaged,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_arvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A rail moves only on a step of the right kind; excluded rails never move.
  a_excluded_holds: assert property (((buckEnable ^ $past(buckEnable)) & ~$past(buckManaged)) == 4'h0)
    else $error("excluded rail changed");
  a_rise_needs_up: assert property ((buckEnable & ~$past(buckEnable)) != 4'h0 |->
    $past(seqZeroEvt.upStep) || $past(seqOneEvt.upStep)) else $error("rail rose without up step");
  a_fall_needs_down: assert property ((~buckEnable & $past(buckEnable)) != 4'h0 |->
    $past(seqZeroEvt.downStep) || $past(seqOneEvt.downStep)) else $error("rail fell without down");
  // Bus answers come in time and stand until taken.
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    && $stable(s_axi_rresp)) else $error("read answer dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  c_rise: cover property ((buckEnable & ~$past(buckEnable)) != 4'h0);
  c_fall: cover property ((~buckEnable & $past(buckEnable)) != 4'h0);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // bsc_top_checker
bind bsc_top bsc_top_checker i_chk (.mclk(mclk), .rst_n(rst_n), .seqZeroEvt(seqZeroEvt),
  .seqOneEvt(seqOneEvt), .buckEnable(buckEnable), .buckManaged(buckManaged),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the buck sequencing bank.
// Assumes the package, the design and its checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [2:0] SLOT [5] = '{3'h6, 3'h7, 3'h7, 3'h0, 3'h0};
  localparam logic [3:0] EXPV [5] = '{4'h0, 4'h1, 4'h7, 4'h6, 4'h0};
  logic                  mclk, rst_n, awV, awR, wV, wR, bV, bR, arV, arR, rV, rR;
  bsc_pkg::bsc_cfg_t     otp [4];
  bsc_pkg::bsc_seq_evt_t evZ, evO;
  logic [3:0]            buckEnable, buckManaged;
  logic [11:0]           awA, arA;
  logic [31:0]           wD, rD, d;
  logic [1:0]            bRsp, rRsp, r;
  int                    fails, n_compared, i;
  bsc_top i_bsc_top (.mclk(mclk), .rst_n(rst_n), .otpBuck0(otp[0]), .otpBuck1(otp[1]),
    .otpBuck2(otp[2]), .otpBuck3(otp[3]), .seqZeroEvt(evZ), .seqOneEvt(evO),
    .buckEnable(buckEnable), .buckManaged(buckManaged), .s_axi_awaddr(awA),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRsp),
    .s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRsp),
    .s_axi_rvalid(rV), .s_axi_rready(rR));
  // The clock free-runs at 10 MHz.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready is sampled on the falling edge, where it equals its value at the next rising edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic da, dw, db;
    {da, dw, db} = 3'b000;
    @(posedge mclk);
    {awA, wD} <= {a, 24'h0, v};
    {awV, wV, bR} <= 3'b111;
    for (int k = 0; k < 40 && !db; k++) begin
      @(negedge mclk);
      da |= awV & awR;
      dw |= wV & wR;
      {db, r} = {bV, bRsp};
      @(posedge mclk);
      {awV, wV, bR} <= {awV & !da, wV & !dw, !db};
    end
    if (!db) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic dr, dd;
    {dr, dd} = 2'b00;
    @(posedge mclk);
    arA <= a;
    {arV, rR} <= 2'b11;
    for (int k = 0; k < 40 && !dd; k++) begin
      @(negedge mclk);
      dr |= arV & arR;
      {dd, r, d} = {rV, rRsp, rD};
      @(posedge mclk);
      {arV, rR} <= {arV & !dr, !dd};
    end
    if (!dd) begin
      fails++;
      report_and_stop();
    end
  endtask
  // One-cycle step pulse; the rail enables are looked at once that edge has landed.
  task automatic step(input logic one, input logic up, input logic [2:0] s);
    @(posedge mclk);
    evZ <= one ? 5'h0 : {up, !up, s};
    evO <= one ? {up, !up, s} : 5'h0;
    @(posedge mclk);
    {evZ, evO} <= 10'h0;
    #1;
  endtask
  function automatic logic [11:0] adr(input int k);
    return {bsc_pkg::IDX_BUCK0_SEQ_CFG + 10'(k), 2'b00};
  endfunction
  // Two passes, so the second reset lands on written bytes after every rail is switched back off.
  initial begin
    {fails, n_compared} = 64'h0;
    {awV, wV, bR, arV, rR} = 5'h00;
    {awA, arA, wD} = 56'h0;
    {evZ, evO} = 10'h0;
    otp = '{8'h1d, 8'h62, 8'ha7, 8'hcb};
    rst_n = 1'b0;
    for (int p = 0; p < 2; p++) begin
      // Reset is asserted on a rising edge, the same as every other input.
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) @(posedge mclk);
      for (i = 0; i < 4; i++) begin
        rd(adr(i));
        chk("reset value", d, {24'h0, otp[i]});
        wr(adr(i), {i[1:0], 6'h38});
        chk("write answer", r, bsc_pkg::RESP_OKAY);
        rd(adr(i));
        chk("readback", d, {24'h0, i[1:0], 6'h38});
      end
      chk("managed", buckManaged, 4'h7);
      wr(12'h000, 8'hff);
      chk("unmapped write", r, bsc_pkg::RESP_SLVERR);
      rd(12'h000);
      chk("unmapped read", r, bsc_pkg::RESP_SLVERR);
      chk("unmapped data", d, 32'h0);
      // The status word is read-only, so a write to it is answered and dropped.
      wr(12'h2c0, 8'hff);
      chk("status write", r, bsc_pkg::RESP_OKAY);
      rd(12'h2c0);
      chk("status word", d, 32'h0000_1670);
      $display("test registers done");
      for (i = 0; i < 5; i++) begin
        step(i == 2 || i == 4, i < 3, SLOT[i]);
        chk("rail enables", buckEnable, EXPV[i]);
      end
      $display("test sequencing done");
    end
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
